// file: hw/rxosp_pkg.sv
// Purpose: shared constants for the receive output and status pin block
// Assumes: 25 MHz system clock, recovered bits arrive as synchronous strobes
// Notes:   holds offset-free constants, slot positions and the enable, interrupt, nibble and select reset values
//
// Contract
// - in parallel mode, deserialise recovered bits into four-bit words on parallel outputs
// - first received bit of each group lands on data bit 3
// - parallel clock is the recovered clock divided down by four
// - parallel data changes on the falling edge of the parallel clock
// - parallel clock keeps toggling during reset; data outputs stay driven
// - during signal loss all four parallel data outputs are held low
// - during signal loss the parallel clock keeps running on last phase
// - during signal loss the serial data output is held at zero
// - serial data is launched on the falling edge of serial clock positive leg
// - during signal loss the serial clock keeps running on last phase
// - signal loss flag is high while signal loss is detected
// - lock loss flag rises when recovered rate differs from reference by over 100 ppm
// - transmit fault interrupt is low on an enabled transmit error event
// - a status register read clears a pending transmit fault interrupt
// - a FIFO recentre pulse clears an interrupt raised by FIFO error
// - transmit lock loss bit falling from one to zero clears the interrupt
// - after reset only transmit lock loss raises the transmit fault interrupt
// - receive fault interrupt outputs are held high, deasserted
// - lock loss flag is meaningful only while no signal loss is present
// - reference select is sampled only at reset release
// - FIFO recentre clears the FIFO error bit; operation resumes on release

package rxosp_pkg;

    // ************************************************************
    // data path geometry
    // ************************************************************
    localparam int unsigned RXOSP_NIBBLE_W   = 4;
    localparam logic [1:0]  RXOSP_NIB_LAST   = 2'h3;   // bit slot that completes a nibble
    localparam logic [1:0]  RXOSP_NIB_RISE   = 2'h1;   // bit slot that raises the par clock

    // ************************************************************
    // reference selection and frequency ratios
    // ************************************************************
    localparam logic [1:0]  RXOSP_SEL_LOW    = 2'h0;   // 19.44 or 17.408 MHz
    localparam logic [1:0]  RXOSP_SEL_FLOAT  = 2'h1;   // 77.76 MHz
    localparam logic [1:0]  RXOSP_SEL_HIGH   = 2'h2;   // 155.52 or 139.264 MHz
    localparam logic [1:0]  RXOSP_SEL_RST    = 2'h0;
    localparam logic [3:0]  RXOSP_RATIO_LOW  = 4'h8;   // line bits per reference tick
    localparam logic [3:0]  RXOSP_RATIO_FLT  = 4'h2;
    localparam logic [3:0]  RXOSP_RATIO_HIGH = 4'h1;

    // parallel clock rates in kHz, line rate divided by the nibble width
    localparam int unsigned RXOSP_PAR_E4_KHZ   = 34816;
    localparam int unsigned RXOSP_PAR_STM1_KHZ = 38880;

    // ************************************************************
    // lock monitor timing
    // ************************************************************
    localparam int unsigned RXOSP_CLK_PERIOD_NS = 40;
    localparam int unsigned RXOSP_LOL_PPM       = 100;
    localparam int unsigned RXOSP_PPM_SCALE     = 1000000;
    localparam int unsigned RXOSP_LOL_WINDOW    = 20000;   // reference ticks per check
    localparam int unsigned RXOSP_CNT_W         = 24;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic        RXOSP_EN_LOL_RST  = 1'b1;
    localparam logic        RXOSP_EN_FIFO_RST = 1'b0;
    localparam logic        RXOSP_IRQ_IDLE_N  = 1'b1;
    localparam logic [3:0]  RXOSP_NIBBLE_RST  = 4'h0;

    // receive path phases
    typedef enum logic [1:0] {
        RXOSP_PH_RESET,
        RXOSP_PH_RUN,
        RXOSP_PH_LOSS
    } rxosp_phase_e;

endpackage

// file: hw/rxosp_tx_irq.sv
// Purpose: transmit fault interrupt and FIFO error status for one channel
// Assumes: all inputs synchronous to clock; read strobe is one cycle
// Notes:   set wins over clear on every pending bit

`timescale 1ns/1ps

module rxosp_tx_irq (
    // clock and reset
    input  wire logic clock,
    input  wire logic sys_rst,
    // transmit status sources
    input  wire logic tx_lock_loss_bit,
    input  wire logic fifo_error_event,
    input  wire logic fifo_recentre,
    input  wire logic status_read,
    // interrupt enables
    input  wire logic cfg_write,
    input  wire logic cfg_en_tx_lol,
    input  wire logic cfg_en_fifo_err,
    // outputs
    output logic      tx_fault_irq_n,
    output logic      fifo_error_bit
);
    import rxosp_pkg::*;

    logic en_lol_reg;
    logic en_fifo_reg;
    logic lol_d_reg;
    logic rec_d_reg;
    logic lol_pend_reg;
    logic fifo_pend_reg;
    logic lol_pend_next;
    logic fifo_pend_next;
    logic lol_rise;
    logic lol_fall;
    logic rec_rise;

    // edge detection on the status levels
    assign lol_rise = tx_lock_loss_bit & ~lol_d_reg;
    assign lol_fall = ~tx_lock_loss_bit & lol_d_reg;
    assign rec_rise = fifo_recentre & ~rec_d_reg;

    // enables; reset leaves only lock loss armed
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            en_lol_reg  <= RXOSP_EN_LOL_RST;
            en_fifo_reg <= RXOSP_EN_FIFO_RST;
        end else if (cfg_write) begin
            en_lol_reg  <= cfg_en_tx_lol;
            en_fifo_reg <= cfg_en_fifo_err;
        end
    end

    // previous levels for edge detection
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            lol_d_reg <= 1'b0;
            rec_d_reg <= 1'b0;
        end else begin
            lol_d_reg <= tx_lock_loss_bit;
            rec_d_reg <= fifo_recentre;
        end
    end

    // pending sources, new event beats a clear in the same cycle
    always_comb begin
        lol_pend_next  = (en_lol_reg & lol_rise) |
                         (lol_pend_reg & ~(status_read | lol_fall));
        fifo_pend_next = (en_fifo_reg & fifo_error_event) |
                         (fifo_pend_reg & ~(status_read | rec_rise));
    end

    // pending state and active-low interrupt pin
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            lol_pend_reg   <= 1'b0;
            fifo_pend_reg  <= 1'b0;
            tx_fault_irq_n <= RXOSP_IRQ_IDLE_N;
        end else begin
            lol_pend_reg   <= lol_pend_next;
            fifo_pend_reg  <= fifo_pend_next;
            tx_fault_irq_n <= ~(lol_pend_next | fifo_pend_next);
        end
    end

    // fifo error status, cleared while recentre is asserted unless a new error event arrives
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            fifo_error_bit <= 1'b0;
        end else begin
            fifo_error_bit <= fifo_error_event |
                              (fifo_error_bit & ~fifo_recentre);
        end
    end

endmodule

// file: hw/rxosp_top.sv
// Purpose: receive output interface and status pins of one line channel
// Assumes: recovered bits come as one-cycle strobes at least two cycles apart
// Notes:   output clocks are built from the bit strobes, so they run in reset

`timescale 1ns/1ps

module rxosp_top #(
    parameter int unsigned LOL_WINDOW = rxosp_pkg::RXOSP_LOL_WINDOW
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // recovered line data from clock recovery
    input  wire logic       rec_bit,
    input  wire logic       rec_bit_valid,
    input  wire logic       los_detect,
    // reference clock tick and selection strap
    input  wire logic       ref_tick,
    input  wire logic [1:0] ref_freq_select,
    // transmit status sources and interrupt configuration
    input  wire logic       tx_lock_loss_bit,
    input  wire logic       fifo_error_event,
    input  wire logic       fifo_recentre,
    input  wire logic       status_read,
    input  wire logic       cfg_write,
    input  wire logic       cfg_en_tx_lol,
    input  wire logic       cfg_en_fifo_err,
    // parallel receive outputs
    output logic [3:0]      par_rx_data,
    output logic            par_rx_clk_out,
    // serial receive outputs
    output logic            ser_rx_data_out_p,
    output logic            ser_rx_data_out_n,
    output logic            ser_rx_clk_out_p,
    output logic            ser_rx_clk_out_n,
    // status pins
    output logic            signal_loss_flag,
    output logic            rx_lock_loss_flag,
    output logic            tx_fault_irq_n,
    output logic            rx_fault_irq_n,
    output logic            fifo_error_bit
);
    import rxosp_pkg::*;

    // ********************
    // declarations
    // ********************
    rxosp_phase_e           phase_reg;
    rxosp_phase_e           phase_next;
    logic [1:0]             slot_reg;
    logic [2:0]             shift_reg;
    logic [1:0]             ref_sel_reg;
    logic [RXOSP_CNT_W-1:0] ref_cnt_reg;
    logic [RXOSP_CNT_W-1:0] bit_cnt_reg;
    logic [RXOSP_CNT_W-1:0] expect_cnt;
    logic [RXOSP_CNT_W-1:0] tol_cnt;
    logic [RXOSP_CNT_W-1:0] diff_cnt;
    logic                   window_end;
    logic                   quiet;

    // ********************
    // helper functions
    // ********************

    // line bits per reference tick for a strap setting
    function automatic logic [3:0] ratio_of(input logic [1:0] sel);
        logic [3:0] r;
        r = RXOSP_RATIO_LOW;
        if (sel == RXOSP_SEL_FLOAT) begin
            r = RXOSP_RATIO_FLT;
        end else if (sel == RXOSP_SEL_HIGH) begin
            r = RXOSP_RATIO_HIGH;
        end
        return r;
    endfunction

    // scale a bit count by the lock tolerance in ppm
    function automatic logic [RXOSP_CNT_W-1:0] ppm_of(input logic [RXOSP_CNT_W-1:0] n);
        longint unsigned p;
        p = (longint'(n) * longint'(RXOSP_LOL_PPM)) / longint'(RXOSP_PPM_SCALE);
        return p[RXOSP_CNT_W-1:0];
    endfunction

    // ********************
    // receive phase
    // ********************

    // next phase from reset and loss detector
    always_comb begin
        phase_next = phase_reg;
        unique case (phase_reg)
            RXOSP_PH_RESET: phase_next = los_detect ? RXOSP_PH_LOSS : RXOSP_PH_RUN;
            RXOSP_PH_RUN:   phase_next = los_detect ? RXOSP_PH_LOSS : RXOSP_PH_RUN;
            RXOSP_PH_LOSS:  phase_next = los_detect ? RXOSP_PH_LOSS : RXOSP_PH_RUN;
        endcase
    end

    // phase register
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            phase_reg <= RXOSP_PH_RESET;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // data outputs are forced quiet whenever loss is seen now
    assign quiet = (phase_next == RXOSP_PH_LOSS);

    // ********************
    // reference selection strap
    // ********************

    // strap followed during reset, frozen at the release edge
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ref_sel_reg <= ref_freq_select;
        end
    end

    // ********************
    // parallel path
    // ********************

    // bit slot within the nibble; parked at zero in reset
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            slot_reg <= 2'h0;
        end else if (rec_bit_valid) begin
            slot_reg <= slot_reg + 2'h1;
        end
    end

    // shift in recovered bits, oldest moves toward the top
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            shift_reg <= 3'h0;
        end else if (rec_bit_valid) begin
            shift_reg <= {shift_reg[1:0], rec_bit};
        end
    end

    // nibble update on the falling edge of the parallel clock
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            par_rx_data <= RXOSP_NIBBLE_RST;   // driven but meaningless in reset
        end else if (quiet) begin
            par_rx_data <= RXOSP_NIBBLE_RST;
        end else if (rec_bit_valid && slot_reg == RXOSP_NIB_LAST) begin
            par_rx_data <= {shift_reg, rec_bit};   // first bit on bit 3
        end
    end

    // divide-by-four parallel clock; follows the strobes while in reset
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            par_rx_clk_out <= ~rec_bit_valid;   // keeps toggling
        end else if (rec_bit_valid && slot_reg == RXOSP_NIB_LAST) begin
            par_rx_clk_out <= 1'b0;   // falls with the data update
        end else if (rec_bit_valid && slot_reg == RXOSP_NIB_RISE) begin
            par_rx_clk_out <= 1'b1;   // still running in loss
        end
    end

    // ********************
    // serial path
    // ********************

    // serial clock low in the strobe cycle, high otherwise; never reset
    always_ff @(posedge clock) begin
        ser_rx_clk_out_p <= ~rec_bit_valid;
        ser_rx_clk_out_n <= rec_bit_valid;
    end

    // serial data launched as the positive clock leg falls
    always_ff @(posedge clock) begin
        if (sys_rst || quiet) begin
            ser_rx_data_out_p <= 1'b0;
            ser_rx_data_out_n <= 1'b1;
        end else if (rec_bit_valid) begin
            ser_rx_data_out_p <= rec_bit;
            ser_rx_data_out_n <= ~rec_bit;
        end
    end

    // ********************
    // status flags
    // ********************

    // loss flag tracks the detector
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            signal_loss_flag <= 1'b0;
        end else begin
            signal_loss_flag <= los_detect;
        end
    end

    // receive fault pin has no function and stays high
    always_ff @(posedge clock) begin
        rx_fault_irq_n <= RXOSP_IRQ_IDLE_N;
    end

    // ********************
    // lock monitor
    // ********************

    // expected count and tolerance for the frozen reference rate
    always_comb begin
        expect_cnt = RXOSP_CNT_W'(LOL_WINDOW) * RXOSP_CNT_W'(ratio_of(ref_sel_reg));
        tol_cnt    = ppm_of(expect_cnt);
        diff_cnt   = (bit_cnt_reg > expect_cnt) ? (bit_cnt_reg - expect_cnt)
                                                : (expect_cnt - bit_cnt_reg);
    end

    assign window_end = ref_tick && (ref_cnt_reg == RXOSP_CNT_W'(LOL_WINDOW - 1));

    // reference ticks within the window; restarts on loss
    always_ff @(posedge clock) begin
        if (sys_rst || los_detect || window_end) begin
            ref_cnt_reg <= '0;
        end else if (ref_tick) begin
            ref_cnt_reg <= ref_cnt_reg + RXOSP_CNT_W'(1);
        end
    end

    // recovered bits within the window
    always_ff @(posedge clock) begin
        if (sys_rst || los_detect || window_end) begin
            bit_cnt_reg <= '0;
        end else if (rec_bit_valid) begin
            bit_cnt_reg <= bit_cnt_reg + RXOSP_CNT_W'(1);
        end
    end

    // lock loss judged once per window; held low while signal is lost
    always_ff @(posedge clock) begin
        if (sys_rst || los_detect) begin
            rx_lock_loss_flag <= 1'b0;
        end else if (window_end) begin
            rx_lock_loss_flag <= (diff_cnt > tol_cnt);
        end
    end

    // ********************
    // transmit fault interrupt
    // ********************
    rxosp_tx_irq u_tx_irq (
        .clock            (clock),
        .sys_rst          (sys_rst),
        .tx_lock_loss_bit (tx_lock_loss_bit),
        .fifo_error_event (fifo_error_event),
        .fifo_recentre    (fifo_recentre),
        .status_read      (status_read),
        .cfg_write        (cfg_write),
        .cfg_en_tx_lol    (cfg_en_tx_lol),
        .cfg_en_fifo_err  (cfg_en_fifo_err),
        .tx_fault_irq_n   (tx_fault_irq_n),
        .fifo_error_bit   (fifo_error_bit)
    );

endmodule

// file: testbench/rxosp_top_monitor.sv
// Purpose: concurrent checks on the ports of the receive output block
// Assumes: one clock domain, sys_rst synchronous and active high
// Notes:   bound into every rxosp_top instance
`timescale 1ns/1ps
module rxosp_top_monitor (
    // clock and reset
    input wire logic       clock,
    input wire logic       sys_rst,
    // block inputs
    input wire logic       rec_bit,
    input wire logic       rec_bit_valid,
    input wire logic       los_detect,
    input wire logic       tx_lock_loss_bit,
    input wire logic       fifo_error_event,
    input wire logic       status_read,
    // block outputs
    input wire logic [3:0] par_rx_data,
    input wire logic       par_rx_clk_out,
    input wire logic       ser_rx_data_out_p,
    input wire logic       ser_rx_clk_out_p,
    input wire logic       rx_fault_irq_n,
    input wire logic       tx_fault_irq_n
);
    logic [3:0] sh_reg;
    logic [2:0] cnt_reg;
    logic [1:0] armed_reg;
    logic       clk_q_reg;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // ********************
    // helper state
    // ********************
    // last four accepted bits, newest at bit 0
    always_ff @(posedge clock) begin
        if (rec_bit_valid) begin
            sh_reg <= {sh_reg[2:0], rec_bit};
        end
    end
    // previous parallel clock level
    always_ff @(posedge clock) begin
        clk_q_reg <= par_rx_clk_out;
    end
    // strobes since last parallel clock rise; skip the rises around reset
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cnt_reg   <= 3'h0;
            armed_reg <= 2'h0;
        end else if (par_rx_clk_out && !clk_q_reg) begin
            cnt_reg   <= {2'h0, rec_bit_valid};
            armed_reg <= (armed_reg == 2'h3) ? 2'h3 : armed_reg + 2'h1;
        end else if (rec_bit_valid) begin
            cnt_reg <= cnt_reg + 3'h1;
        end
    end
    // ********************
    // properties
    // ********************
    property p_ser_data;
        rec_bit_valid && !los_detect |=> ser_rx_data_out_p == $past(rec_bit);
    endproperty
    a_ser_data: assert property (p_ser_data) else $error("serial bit wrong");
    property p_los_force;
        los_detect |=> par_rx_data == 4'h0 && !ser_rx_data_out_p;
    endproperty
    a_los_force: assert property (p_los_force) else $error("loss not forced");
    property p_ser_launch;
        $changed(ser_rx_data_out_p) && !$past(los_detect) && !$past(sys_rst)
            |-> $fell(ser_rx_clk_out_p);
    endproperty
    a_ser_launch: assert property (p_ser_launch) else $error("serial launch edge");
    property p_par_launch;
        $changed(par_rx_data) && !$past(los_detect) && !$past(sys_rst)
            |-> $fell(par_rx_clk_out);
    endproperty
    a_par_launch: assert property (p_par_launch) else $error("nibble launch edge");
    property p_nibble;
        $fell(par_rx_clk_out) && !$past(los_detect) && !$past(sys_rst) |-> par_rx_data == sh_reg;
    endproperty
    a_nibble: assert property (p_nibble) else $error("nibble content");
    property p_par_div;
        $rose(par_rx_clk_out) && armed_reg >= 2'h2 |-> cnt_reg == 3'h4;
    endproperty
    a_par_div: assert property (p_par_div) else $error("parallel clock ratio");
    property p_rx_irq;
        1'h1 |-> rx_fault_irq_n;
    endproperty
    a_rx_irq: assert property (p_rx_irq) else $error("receive irq asserted");
    property p_irq_read;
        status_read && !tx_fault_irq_n && !$rose(tx_lock_loss_bit) && !fifo_error_event
            |=> tx_fault_irq_n;
    endproperty
    a_irq_read: assert property (p_irq_read) else $error("read kept irq");
endmodule

bind rxosp_top rxosp_top_monitor u_mon (
    .clock(clock), .sys_rst(sys_rst), .rec_bit(rec_bit), .rec_bit_valid(rec_bit_valid),
    .los_detect(los_detect), .tx_lock_loss_bit(tx_lock_loss_bit),
    .fifo_error_event(fifo_error_event), .status_read(status_read),
    .par_rx_data(par_rx_data), .par_rx_clk_out(par_rx_clk_out),
    .ser_rx_data_out_p(ser_rx_data_out_p), .ser_rx_clk_out_p(ser_rx_clk_out_p),
    .rx_fault_irq_n(rx_fault_irq_n), .tx_fault_irq_n(tx_fault_irq_n)
);

// file: testbench/rxosp_framer_model.sv
// Purpose: downstream framer, takes nibbles off the parallel bus
// Assumes: parallel clock sampled with the system clock
// Notes:   held idle while the block is in reset
`timescale 1ns/1ps
module rxosp_framer_model (
    // clock and hold
    input wire logic       clock,
    input wire logic       hold,
    // parallel receive bus
    input wire logic [3:0] par_rx_data,
    input wire logic       par_rx_clk_out
);
    logic       clk_q_reg;
    logic [3:0] got[$];
    // sample the nibble at each rising edge of the parallel clock
    always @(posedge clock) begin
        clk_q_reg <= par_rx_clk_out;
        if (!hold && par_rx_clk_out && !clk_q_reg) begin
            got.push_back(par_rx_data);
        end
    end
endmodule

// file: testbench/rx_output_and_status_pins_tb.sv
// Purpose: self-checking bench for the receive output block
// Assumes: 25 MHz clock, inputs change on the falling edge
// Notes:   short lock window keeps the run brief
`timescale 1ns/1ps
module rx_output_and_status_pins_tb;
    import rxosp_pkg::*;
    localparam int LW = 200;
    logic        clock, sys_rst, rec_bit, rec_bit_valid, los_detect, ref_tick;
    logic [1:0]  ref_freq_select;
    logic        tx_lock_loss_bit, fifo_error_event, fifo_recentre, status_read;
    logic        cfg_write, cfg_en_tx_lol, cfg_en_fifo_err, par_rx_clk_out;
    logic [3:0]  par_rx_data;
    logic        ser_p, ser_n, ser_ck_p, ser_ck_n, signal_loss_flag, rx_lock_loss_flag;
    logic        tx_fault_irq_n, rx_fault_irq_n, fifo_error_bit, v_s, b_s, los_s, rst_s;
    logic [31:0] rnd;
    logic        bits[$];
    int          n_fail = 0, n_checks = 0, ph = 0, tick_per = 16, seed = 32'h0cec;

    rxosp_top #(.LOL_WINDOW(LW)) dut (
        .clock(clock), .sys_rst(sys_rst), .rec_bit(rec_bit), .rec_bit_valid(rec_bit_valid),
        .los_detect(los_detect), .ref_tick(ref_tick), .ref_freq_select(ref_freq_select),
        .tx_lock_loss_bit(tx_lock_loss_bit), .fifo_error_event(fifo_error_event),
        .fifo_recentre(fifo_recentre), .status_read(status_read), .cfg_write(cfg_write),
        .cfg_en_tx_lol(cfg_en_tx_lol), .cfg_en_fifo_err(cfg_en_fifo_err),
        .par_rx_data(par_rx_data), .par_rx_clk_out(par_rx_clk_out),
        .ser_rx_data_out_p(ser_p), .ser_rx_data_out_n(ser_n), .ser_rx_clk_out_p(ser_ck_p),
        .ser_rx_clk_out_n(ser_ck_n), .signal_loss_flag(signal_loss_flag),
        .rx_lock_loss_flag(rx_lock_loss_flag), .tx_fault_irq_n(tx_fault_irq_n),
        .rx_fault_irq_n(rx_fault_irq_n), .fifo_error_bit(fifo_error_bit)
    );
    rxosp_framer_model u_fr (.clock(clock), .hold(sys_rst), .par_rx_data(par_rx_data),
                             .par_rx_clk_out(par_rx_clk_out));

    // ********************
    // clock, stimulus and running checks
    // ********************
    // 40 ns system clock
    initial begin
        clock = 1'h0;
        forever #20 clock = ~clock;
    end
    // capture what the block saw at each rising edge
    always @(posedge clock) begin
        {v_s, b_s, los_s, rst_s} <= {rec_bit_valid, rec_bit, los_detect, sys_rst};
        if (rec_bit_valid && !sys_rst) bits.push_back(rec_bit);
    end
    // random bits every other cycle, reference ticks off the strobe phase
    always @(negedge clock) begin
        ph = ph + 1;
        rnd = $random(seed);
        rec_bit = rnd[0];
        rec_bit_valid = (ph % 2 == 0);
        ref_tick = (ph % tick_per == 1);
        if (!rst_s) begin
            chk1(signal_loss_flag, los_s);
            if (v_s) chk1(ser_p, !los_s && b_s);
            if (v_s) chk1(ser_n, los_s || !b_s);
            chk1(ser_ck_p, !v_s);
            chk1(ser_ck_n, v_s);
        end
    end
    // give up if the tests hang
    initial begin
        repeat (80000) @(posedge clock);
        n_fail++;
        $display("[FAIL] %0t watchdog expired", $time);
        final_report;
    end

    // ********************
    // tasks and expectations
    // ********************
    task automatic chk1(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t flag got %b want %b", $time, got, exp);
        end
    endtask
    task automatic chk4(input logic [3:0] got, input logic [3:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t nibble got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic wait_bits(input int n);
        while (bits.size() < n) @(negedge clock);
    endtask
    function automatic logic [3:0] exp_nib(input int i);
        return {bits[4*i], bits[4*i+1], bits[4*i+2], bits[4*i+3]};
    endfunction
    function automatic logic exp_lol(input int tp, input int r);
        int have, want, d;
        have = LW * tp / 2;
        want = LW * r;
        d = (have > want) ? have - want : want - have;
        return d * RXOSP_PPM_SCALE > want * RXOSP_LOL_PPM;
    endfunction
    // reset for five cycles with strobes running, then align the framer
    task automatic do_reset(input logic [1:0] sel);
        int   tog;
        logic prev;
        tog = 0;
        @(negedge clock);
        ref_freq_select = sel;
        sys_rst = 1'h1;
        prev = par_rx_clk_out;
        repeat (5) begin
            @(negedge clock);
            tog = tog + (par_rx_clk_out !== prev);
            prev = par_rx_clk_out;
        end
        chk1(tog > 1, 1'h1);
        sys_rst = 1'h0;
        bits.delete();
        wait_bits(5);
        u_fr.got.delete();
    endtask
    task automatic lol_case(input logic [1:0] sel, input int off);
        int r;
        r = (sel == RXOSP_SEL_FLOAT) ? RXOSP_RATIO_FLT :
            (sel == RXOSP_SEL_HIGH) ? RXOSP_RATIO_HIGH : RXOSP_RATIO_LOW;
        tick_per = 2 * r + off;
        do_reset(sel);
        ref_freq_select = ~sel;
        tick(3 * LW * tick_per + 20);
        chk1(rx_lock_loss_flag, exp_lol(tick_per, r));
        $display("test lock select %0d offset %0d done", sel, off);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ********************
    // main sequence
    // ********************
    initial begin
        {sys_rst, los_detect} = 2'h2;
        {tx_lock_loss_bit, fifo_error_event, fifo_recentre, status_read} = 4'h0;
        {cfg_write, cfg_en_tx_lol, cfg_en_fifo_err} = 3'h0;
        ref_freq_select = RXOSP_SEL_LOW;
        do_reset(RXOSP_SEL_LOW);
        fifo_error_event = 1'h1;
        tick(1);
        fifo_error_event = 1'h0;
        tick(1);
        chk1(fifo_error_bit, 1'h1);
        chk1(tx_fault_irq_n, 1'h1);
        fifo_recentre = 1'h1;
        tick(2);
        chk1(fifo_error_bit, 1'h0);
        fifo_recentre = 1'h0;
        tx_lock_loss_bit = 1'h1;
        tick(2);
        chk1(tx_fault_irq_n, 1'h0);
        status_read = 1'h1;
        tick(1);
        status_read = 1'h0;
        tick(1);
        chk1(tx_fault_irq_n, 1'h1);
        tx_lock_loss_bit = 1'h0;
        tick(2);
        tx_lock_loss_bit = 1'h1;
        tick(2);
        chk1(tx_fault_irq_n, 1'h0);
        tx_lock_loss_bit = 1'h0;
        tick(2);
        chk1(tx_fault_irq_n, 1'h1);
        {cfg_write, cfg_en_tx_lol, cfg_en_fifo_err} = 3'h5;
        tick(1);
        cfg_write = 1'h0;
        tx_lock_loss_bit = 1'h1;
        tick(2);
        chk1(tx_fault_irq_n, 1'h1);
        fifo_error_event = 1'h1;
        tick(1);
        fifo_error_event = 1'h0;
        tick(1);
        chk1(tx_fault_irq_n, 1'h0);
        fifo_recentre = 1'h1;
        tick(2);
        fifo_recentre = 1'h0;
        chk1(tx_fault_irq_n, 1'h1);
        tx_lock_loss_bit = 1'h0;
        $display("test transmit interrupt done");
        do_reset(RXOSP_SEL_LOW);
        wait_bits(9);
        los_detect = 1'h1;
        wait_bits(21);
        chk4(par_rx_data, 4'h0);
        chk1(rx_lock_loss_flag, 1'h0);
        los_detect = 1'h0;
        wait_bits(37);
        for (int i = 0; i < u_fr.got.size() && 4 * i + 3 < bits.size(); i++)
            chk4(u_fr.got[i], (i >= 1 && i <= 4) ? 4'h0 : exp_nib(i));
        chk1(u_fr.got.size() >= 7, 1'h1);
        $display("test data path and signal loss done");
        for (int k = 0; k < 8; k++) lol_case(k % 4, k / 4 * 2);
        final_report;
    end
endmodule
